// File: dat_params.svh
`ifndef DAT_PARAMS_SVH
`define DAT_PARAMS_SVH
`define DAT_ADDR_AVG_CFG   8'h4b
`define DAT_ADDR_BIAS_HI   8'h4c
`define DAT_ADDR_BIAS_LO   8'h4d
`define DAT_ADDR_AUX_HI    8'h4e
`define DAT_ADDR_AUX_LO    8'h4f
`define DAT_RST_AVG_CFG    8'h00
`define DAT_RST_BIAS_HI    8'ha2
`define DAT_RST_BIAS_LO    8'h48
`define DAT_RST_AUX_HI     8'hba
`define DAT_RST_AUX_LO     8'h4b
`define DAT_SEL_MSB        7
`define DAT_SEL_LSB        6
`define DAT_BYP_BIAS_BIT   5
`define DAT_BYP_TEMP_BIT   4
`define DAT_BYP_AUX_BIT    3
`define DAT_LIMIT_SHIFT    4
`endif

// File: dat_pkg.sv
`default_nettype none
package dat_pkg;
    typedef enum logic [1:0] {
        dat_avg_off     = 2'h0,
        dat_avg_half    = 2'h1,
        dat_avg_quarter = 2'h2,
        dat_avg_rsvd    = 2'h3
    } dat_avg_sel_t;
    typedef struct packed {
        logic        valid;
        logic [11:0] value;
    } dat_sample_t;
    typedef struct packed {
        logic       write;
        logic       read;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dat_reg_req_t;
endpackage
`default_nettype wire

// File: dat_smoother.sv
`timescale 1ns/1ps
`default_nettype none
`include "dat_params.svh"
module dat_smoother (
    input  wire logic               mclk,
    input  wire logic               rst_b,
    input  wire dat_pkg::dat_avg_sel_t sel,
    input  wire logic               bypass,
    input  wire dat_pkg::dat_sample_t  sample,
    output dat_pkg::dat_sample_t    smoothed
);
    logic [11:0] held;
    logic        primed;
    logic [13:0] next_value;

    always_comb begin
        next_value = {2'h0, sample.value};
        if (!bypass && primed) begin
            unique case (sel)
                dat_pkg::dat_avg_half:
                    next_value = ({2'h0, sample.value} + {2'h0, held})
                        >> 1;
                dat_pkg::dat_avg_quarter:
                    next_value = ({2'h0, sample.value} + {2'h0, held}
                        + {1'h0, held, 1'h0}) >> 2;
                default:
                    next_value = {2'h0, sample.value};
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            held   <= 12'h000;
            primed <= 1'b0;
        end else if (sample.valid) begin
            held   <= next_value[11:0];
            primed <= 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            smoothed <= '0;
        end else begin
            smoothed.valid <= sample.valid;
            if (sample.valid) begin
                smoothed.value <= next_value[11:0];
            end
        end
    end
endmodule
`default_nettype wire

// File: dat_limit_check.sv
`timescale 1ns/1ps
`default_nettype none
`include "dat_params.svh"
module dat_limit_check (
    input  wire logic              mclk,
    input  wire logic              rst_b,
    input  wire dat_pkg::dat_sample_t reading,
    input  wire logic [7:0]        upper_code,
    input  wire logic [7:0]        lower_code,
    output logic                   high_fault,
    output logic                   low_fault
);
    logic [11:0] upper_scaled;
    logic [11:0] lower_scaled;

    assign upper_scaled = {upper_code, 4'h0};
    assign lower_scaled = {lower_code, 4'h0};

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            high_fault <= 1'b0;
            low_fault  <= 1'b0;
        end else if (reading.valid) begin
            high_fault <= reading.value > upper_scaled;
            low_fault  <= reading.value < lower_scaled;
        end
    end
endmodule
`default_nettype wire

// File: dat_diag_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "dat_params.svh"
module dat_diag_top (
    input  wire logic                mclk,
    input  wire logic                rst_b,
    input  wire dat_pkg::dat_reg_req_t  reg_req,
    output logic [7:0]               reg_rdata,
    input  wire dat_pkg::dat_sample_t   bias_load_sample,
    input  wire dat_pkg::dat_sample_t   temperature_sample,
    input  wire dat_pkg::dat_sample_t   aux_analog_sample,
    output dat_pkg::dat_sample_t     bias_load_out,
    output dat_pkg::dat_sample_t     temperature_out,
    output dat_pkg::dat_sample_t     aux_analog_out,
    output logic                     bias_high_fault,
    output logic                     bias_low_fault,
    output logic                     aux_high_fault,
    output logic                     aux_low_fault
);
    logic [4:0] diag_average_config;
    logic [7:0] bias_high_current_limit;
    logic [7:0] bias_low_current_limit;
    logic [7:0] aux_analog_upper_limit;
    logic [7:0] aux_analog_lower_limit;
    dat_pkg::dat_avg_sel_t average_weight_select;
    logic       bias_load_average_bypass;
    logic       temperature_average_bypass;
    logic       aux_analog_average_bypass;
    dat_pkg::dat_sample_t bias_smooth;
    dat_pkg::dat_sample_t aux_smooth;
    dat_pkg::dat_sample_t temp_smooth;
    logic [7:0] next_rdata;

    assign average_weight_select =
        dat_pkg::dat_avg_sel_t'(diag_average_config[4:3]);
    assign bias_load_average_bypass   = diag_average_config[2];
    assign temperature_average_bypass = diag_average_config[1];
    assign aux_analog_average_bypass  = diag_average_config[0];

    // Register writes
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            diag_average_config     <=
                5'(`DAT_RST_AVG_CFG >> `DAT_BYP_AUX_BIT);
            bias_high_current_limit <= `DAT_RST_BIAS_HI;
            bias_low_current_limit  <= `DAT_RST_BIAS_LO;
            aux_analog_upper_limit  <= `DAT_RST_AUX_HI;
            aux_analog_lower_limit  <= `DAT_RST_AUX_LO;
        end else if (reg_req.write) begin
            unique case (reg_req.addr)
                `DAT_ADDR_AVG_CFG:
                    diag_average_config <=
                        reg_req.wdata[`DAT_SEL_MSB:`DAT_BYP_AUX_BIT];
                `DAT_ADDR_BIAS_HI:
                    bias_high_current_limit <= reg_req.wdata;
                `DAT_ADDR_BIAS_LO:
                    bias_low_current_limit <= reg_req.wdata;
                `DAT_ADDR_AUX_HI:
                    aux_analog_upper_limit <= reg_req.wdata;
                `DAT_ADDR_AUX_LO:
                    aux_analog_lower_limit <= reg_req.wdata;
                default: ;
            endcase
        end
    end

    // Register reads
    always_comb begin
        unique case (reg_req.addr)
            `DAT_ADDR_AVG_CFG:
                next_rdata = {diag_average_config, 3'h0};
            `DAT_ADDR_BIAS_HI: next_rdata = bias_high_current_limit;
            `DAT_ADDR_BIAS_LO: next_rdata = bias_low_current_limit;
            `DAT_ADDR_AUX_HI:  next_rdata = aux_analog_upper_limit;
            `DAT_ADDR_AUX_LO:  next_rdata = aux_analog_lower_limit;
            default:           next_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 8'h00;
        end else if (reg_req.read) begin
            reg_rdata <= next_rdata;
        end
    end

    dat_smoother u_bias_smooth (
        .mclk     (mclk),
        .rst_b    (rst_b),
        .sel      (average_weight_select),
        .bypass   (bias_load_average_bypass),
        .sample   (bias_load_sample),
        .smoothed (bias_smooth)
    );

    dat_smoother u_temp_smooth (
        .mclk     (mclk),
        .rst_b    (rst_b),
        .sel      (average_weight_select),
        .bypass   (temperature_average_bypass),
        .sample   (temperature_sample),
        .smoothed (temp_smooth)
    );

    dat_smoother u_aux_smooth (
        .mclk     (mclk),
        .rst_b    (rst_b),
        .sel      (average_weight_select),
        .bypass   (aux_analog_average_bypass),
        .sample   (aux_analog_sample),
        .smoothed (aux_smooth)
    );

    dat_limit_check u_bias_check (
        .mclk       (mclk),
        .rst_b      (rst_b),
        .reading    (bias_smooth),
        .upper_code (bias_high_current_limit),
        .lower_code (bias_low_current_limit),
        .high_fault (bias_high_fault),
        .low_fault  (bias_low_fault)
    );

    dat_limit_check u_aux_check (
        .mclk       (mclk),
        .rst_b      (rst_b),
        .reading    (aux_smooth),
        .upper_code (aux_analog_upper_limit),
        .lower_code (aux_analog_lower_limit),
        .high_fault (aux_high_fault),
        .low_fault  (aux_low_fault)
    );

    // Output copies of smoothed readings
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            bias_load_out   <= '0;
            temperature_out <= '0;
            aux_analog_out  <= '0;
        end else begin
            bias_load_out   <= bias_smooth;
            temperature_out <= temp_smooth;
            aux_analog_out  <= aux_smooth;
        end
    end
endmodule
`default_nettype wire

// File: dat_diag_checker.sv
`timescale 1ns/1ps
`default_nettype none
`include "dat_params.svh"
module dat_diag_checker (
    input wire logic                  mclk,
    input wire logic                  rst_b,
    input wire dat_pkg::dat_reg_req_t reg_req,
    input wire logic [7:0]            reg_rdata,
    input wire dat_pkg::dat_sample_t  bias_load_sample,
    input wire dat_pkg::dat_sample_t  temperature_sample,
    input wire dat_pkg::dat_sample_t  aux_analog_sample,
    input wire dat_pkg::dat_sample_t  bias_load_out,
    input wire dat_pkg::dat_sample_t  temperature_out,
    input wire dat_pkg::dat_sample_t  aux_analog_out,
    input wire logic                  bias_high_fault,
    input wire logic                  bias_low_fault,
    input wire logic                  aux_high_fault,
    input wire logic                  aux_low_fault
);
    logic [7:0] cfg;
    logic [7:0] bhi;
    // Shadow copies of the config and bias upper limit
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) cfg <= `DAT_RST_AVG_CFG;
        else if (reg_req.write && reg_req.addr == `DAT_ADDR_AVG_CFG)
            cfg <= reg_req.wdata;
    end
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) bhi <= `DAT_RST_BIAS_HI;
        else if (reg_req.write && reg_req.addr == `DAT_ADDR_BIAS_HI)
            bhi <= reg_req.wdata;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_b);
    sequence s_aux_in;
        aux_analog_sample.valid && (cfg[3] || cfg[7:6] == 2'h0);
    endsequence
    sequence s_aux_raw;
        ##2 aux_analog_out.value == $past(aux_analog_sample.value, 2);
    endsequence
    property p_bias_lat;
        bias_load_sample.valid |-> ##2 bias_load_out.valid;
    endproperty
    property p_aux_lat;
        aux_analog_sample.valid |-> ##2 aux_analog_out.valid;
    endproperty
    property p_out_cause;
        bias_load_out.valid |-> $past(bias_load_sample.valid, 2);
    endproperty
    property p_bias_byp;
        bias_load_sample.valid && cfg[5] |-> ##2
            bias_load_out.value == $past(bias_load_sample.value, 2);
    endproperty
    property p_temp_byp;
        temperature_sample.valid && cfg[4] |-> ##2
            temperature_out.value == $past(temperature_sample.value, 2);
    endproperty
    property p_aux_raw;
        s_aux_in |-> s_aux_raw;
    endproperty
    property p_bias_hi;
        bias_load_out.valid |=>
            bias_high_fault == (bias_load_out.value > {bhi, 4'h0});
    endproperty
    property p_aux_hold;
        !aux_analog_out.valid |-> $stable(aux_low_fault);
    endproperty
    property p_cfg_low;
        reg_req.read && reg_req.addr == `DAT_ADDR_AVG_CFG
            |=> reg_rdata[2:0] == 3'h0;
    endproperty
    a_bias_lat: assert property (p_bias_lat)
        else $error("bias output late");
    a_aux_lat: assert property (p_aux_lat)
        else $error("aux output late");
    a_out_cause: assert property (p_out_cause)
        else $error("bias output without sample");
    a_bias_byp: assert property (p_bias_byp)
        else $error("bias bypass failed");
    a_temp_byp: assert property (p_temp_byp)
        else $error("temperature bypass failed");
    a_aux_raw: assert property (p_aux_raw)
        else $error("aux raw pass failed");
    a_bias_hi: assert property (p_bias_hi)
        else $error("bias high fault wrong");
    a_aux_hold: assert property (p_aux_hold)
        else $error("aux low fault moved");
    a_cfg_low: assert property (p_cfg_low)
        else $error("config low bits not zero");
endmodule
`default_nettype wire

// File: diag_average_threshold_cfg_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "dat_params.svh"
module diag_average_threshold_cfg_bench;
    logic                  mclk = 1'b0;
    logic                  rst_b = 1'b0;
    dat_pkg::dat_reg_req_t req = '0;
    logic [7:0]            rdata;
    dat_pkg::dat_sample_t  smp [3];
    dat_pkg::dat_sample_t  outs [3];
    wire  [3:0]            flt;
    int                    n_mismatch = 0;
    int                    check_count = 0;
    int                    hist [3];
    bit                    primed [3] = '{0, 0, 0};
    int                    lim [4] = '{`DAT_RST_BIAS_HI, `DAT_RST_BIAS_LO,
                                       `DAT_RST_AUX_HI, `DAT_RST_AUX_LO};
    logic [7:0]            cfg = 8'h00;
    always #12.5 mclk = ~mclk;
    dat_diag_top uut (.mclk(mclk), .rst_b(rst_b), .reg_req(req),
        .reg_rdata(rdata), .bias_load_sample(smp[0]),
        .temperature_sample(smp[1]), .aux_analog_sample(smp[2]),
        .bias_load_out(outs[0]), .temperature_out(outs[1]),
        .aux_analog_out(outs[2]), .bias_high_fault(flt[3]),
        .bias_low_fault(flt[2]), .aux_high_fault(flt[1]),
        .aux_low_fault(flt[0]));
    task automatic bump(input bit bad, input string what);
        check_count++;
        if (bad) begin
            n_mismatch++;
            $display("wrong value at %0t: %s", $time, what);
        end
    endtask
    task automatic cmp_reg(input logic [7:0] g, input logic [7:0] e);
        bump(g !== e, "register");
    endtask
    task automatic cmp_smp(input logic [12:0] g, input logic [12:0] e);
        bump(g !== e, "output sample");
    endtask
    task automatic cmp_flt(input logic g, input logic e);
        bump(g !== e, "fault flag");
    endtask
    function automatic logic [7:0] exp_reg(input int a);
        if (a == `DAT_ADDR_AVG_CFG) return cfg;
        if (a >= `DAT_ADDR_BIAS_HI && a <= `DAT_ADDR_AUX_LO)
            return lim[a - `DAT_ADDR_BIAS_HI][7:0];
        return 8'h00;
    endfunction
    task automatic wr(input int a, input logic [7:0] d);
        @(posedge mclk);
        req <= '{1'b1, 1'b0, a[7:0], d};
        @(posedge mclk);
        req <= '0;
        if (a == `DAT_ADDR_AVG_CFG) cfg = d;
        else if (a <= `DAT_ADDR_AUX_LO) lim[a - `DAT_ADDR_BIAS_HI] = d;
    endtask
    task automatic rd_chk(input int a);
        @(posedge mclk);
        req <= '{1'b0, 1'b1, a[7:0], 8'h00};
        @(posedge mclk);
        req <= '0;
        @(negedge mclk);
        cmp_reg(rdata, exp_reg(a));
    endtask
    task automatic send(input logic [11:0] v [3]);
        int e [3];
        @(posedge mclk);
        foreach (smp[i]) smp[i] <= '{1'b1, v[i]};
        @(posedge mclk);
        foreach (smp[i]) smp[i] <= '{1'b0, ~v[i]};
        foreach (e[i]) begin
            e[i] = v[i];
            if (primed[i] && !cfg[5 - i] && cfg[7:6] == 2'h1)
                e[i] = (v[i] + hist[i]) >> 1;
            if (primed[i] && !cfg[5 - i] && cfg[7:6] == 2'h2)
                e[i] = (v[i] + 3 * hist[i]) >> 2;
            hist[i] = e[i];
            primed[i] = 1'b1;
        end
        @(posedge mclk);
        @(negedge mclk);
        foreach (e[i])
            cmp_smp(outs[i], {1'b1, 12'(e[i])});
        @(negedge mclk);
        cmp_flt(flt[3], e[0] > lim[0] * 16);
        cmp_flt(flt[2], e[0] < lim[1] * 16);
        cmp_flt(flt[1], e[2] > lim[2] * 16);
        cmp_flt(flt[0], e[2] < lim[3] * 16);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        logic [11:0] v [3];
        foreach (smp[i]) smp[i] = '0;
        void'($urandom(32'h3e6b52e2));
        repeat (3) @(posedge mclk);
        rst_b <= 1'b1;
        for (int a = `DAT_ADDR_AVG_CFG; a <= `DAT_ADDR_AUX_LO + 1; a++)
            rd_chk(a);
        $display("test reset values done");
        for (int a = `DAT_ADDR_BIAS_HI; a <= `DAT_ADDR_AUX_LO + 1; a++)
            wr(a, 8'($urandom));
        for (int a = `DAT_ADDR_AVG_CFG; a <= `DAT_ADDR_AUX_LO + 1; a++)
            rd_chk(a);
        $display("test register write done");
        for (int k = 0; k < 24; k++) begin
            wr(`DAT_ADDR_AVG_CFG,
                {2'(k % 3), 3'(k / 3), 3'h0});
            rd_chk(`DAT_ADDR_AVG_CFG);
            repeat (4) begin
                foreach (v[i]) v[i] = 12'($urandom);
                send(v);
            end
        end
        $display("test smoothing and limits done");
        tally_and_finish();
    end
endmodule
bind dat_diag_top dat_diag_checker u_chk (.mclk(mclk), .rst_b(rst_b),
    .reg_req(reg_req), .reg_rdata(reg_rdata),
    .bias_load_sample(bias_load_sample),
    .temperature_sample(temperature_sample),
    .aux_analog_sample(aux_analog_sample), .bias_load_out(bias_load_out),
    .temperature_out(temperature_out), .aux_analog_out(aux_analog_out),
    .bias_high_fault(bias_high_fault), .bias_low_fault(bias_low_fault),
    .aux_high_fault(aux_high_fault), .aux_low_fault(aux_low_fault));
`default_nettype wire
